// >>> hw/cid_core.sv
`timescale 1ns/1ps
`include "cid_defs.svh"
// What this block does
// RL1: Each instruction is one, two or three bytes long, and the length is known from the opcode.
// RL2: A one-byte instruction is the opcode alone with any operand implied by it.
// RL3: A two-byte instruction is the opcode followed by one operand byte.
// RL4: A three-byte instruction is the opcode then two operand bytes from consecutive addresses.
// RL5: A relative branch adds its signed 8-bit displacement to the program counter when taken.
// RL6: A direct operand is an 8-bit address naming internal data memory or a special register.
// RL7: A working register operand picks one of eight registers in the selected bank.
// RL8: An indirect pointer is register 0 or 1 of the current bank, holding the address used.
// RL9: External data moves take extra cycles set by a 3-bit timing field.
// RL10: Every instruction takes its tabulated byte and cycle count.
// RL11: Adds update carry, aux carry, overflow and parity; moves keep the first three.
// RL12: Multiply puts the product low byte in the accumulator, the high byte in the aux register.
// RL13: Rotate left turns the accumulator left by one bit without the carry.
module cid_core
   import cid_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   output logic [15:0] progAddr,
   output logic progRd,
   input wire logic [7:0] progData,
   input wire logic [1:0] bankSel,
   input wire logic [2:0] external_move_timing_ctrl,
   output logic [15:0] data_pointer_pair,
   output logic xdataWr,
   output logic [7:0] xdataWdata,
   input wire logic [7:0] xdataRdata,
   output logic [7:0] accOut,
   output logic [7:0] auxRegOut,
   output logic carryFlag,
   output logic auxCarryFlag,
   output logic overflowFlag,
   output logic parityFlag,
   output logic instrDone,
   output logic [1:0] instrLen,
   output logic [3:0] instrCycles
);
   cid_state_e state, next_state;
   logic [15:0] pc, next_pc, next_dataPtr, next_progAddr;
   logic [7:0] opcode, next_opcode, op1, next_op1, op2, next_op2;
   logic [7:0] next_acc, next_b, next_xdataWdata;
   logic [1:0] byteIdx, next_byteIdx, next_instrLen, decLen;
   logic [3:0] waitCnt, next_waitCnt, next_instrCycles, decCycles;
   logic next_carry, next_aux, next_overflow, next_progRd, next_done, next_xdataWr;
   logic [7:0] idata [0:255];
   logic memWr;
   logic [7:0] memAddr, memData, regAddr, ptrAddr, ptrVal, srcVal, dstAddr, dstVal;
   logic dstEn;
   logic [8:0] sum9;
   logic [4:0] sumLow;
   logic [15:0] product;
   logic carryIn;

   cid_len_decode u_dec (
      .opcode(progData),
      .moveTiming(external_move_timing_ctrl),
      .byteLen(decLen),
      .cycles(decCycles)
   );

   ////////////////////////////////////////////////////////////////////
   // Operand addressing
   function automatic logic [7:0] readDirect(input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      if (!a[7]) begin
         v = idata[a]; // RL6
      end else if (a == `CID_SFR_ACC) begin
         v = accOut;
      end else if (a == `CID_SFR_B) begin
         v = auxRegOut;
      end else if (a == `CID_SFR_DPL) begin
         v = data_pointer_pair[7:0];
      end else if (a == `CID_SFR_DPH) begin
         v = data_pointer_pair[15:8];
      end
      return v;
   endfunction : readDirect

   assign regAddr = {3'b000, bankSel, opcode[2:0]}; // RL7
   assign ptrAddr = {3'b000, bankSel, 2'b00, opcode[0]}; // RL8
   assign ptrVal = idata[ptrAddr]; // RL8

   always_comb begin
      case (opcode[3:0])
         4'h4: srcVal = op1;
         4'h5: srcVal = readDirect(op1);
         4'h6, 4'h7: srcVal = idata[ptrVal]; // RL8
         default: srcVal = idata[regAddr]; // RL7
      endcase
   end

   assign carryIn = (opcode[7:4] == 4'h3) ? carryFlag : 1'b0;
   assign sum9 = {1'b0, accOut} + {1'b0, srcVal} + {8'h00, carryIn};
   assign sumLow = {1'b0, accOut[3:0]} + {1'b0, srcVal[3:0]} + {4'h0, carryIn};
   assign product = accOut * auxRegOut;

   ////////////////////////////////////////////////////////////////////
   // Fetch and execute sequencing
   always_comb begin
      next_state = state;
      next_pc = pc;
      next_opcode = opcode;
      next_op1 = op1;
      next_op2 = op2;
      next_byteIdx = byteIdx;
      next_waitCnt = waitCnt;
      next_instrLen = instrLen;
      next_instrCycles = instrCycles;
      next_acc = accOut;
      next_b = auxRegOut;
      next_dataPtr = data_pointer_pair;
      next_carry = carryFlag;
      next_aux = auxCarryFlag;
      next_overflow = overflowFlag;
      next_progRd = 1'b0;
      next_progAddr = progAddr;
      next_done = 1'b0;
      next_xdataWr = 1'b0;
      next_xdataWdata = xdataWdata;
      dstEn = 1'b0;
      dstAddr = op1;
      dstVal = accOut;
      memWr = 1'b0;
      memAddr = regAddr;
      memData = accOut;
      case (state)
         CID_REQ: begin
            next_progRd = 1'b1;
            next_progAddr = pc;
            next_pc = pc + 16'h0001;
            next_state = CID_WAIT;
         end
         CID_WAIT: begin
            next_state = CID_CAP;
         end
         CID_CAP: begin
            next_state = CID_REQ;
            if (byteIdx == 2'd0) begin
               next_opcode = progData;
               next_instrLen = decLen; // RL1
               next_instrCycles = decCycles;
               next_waitCnt = decCycles - 4'h1; // RL10
               if (decLen == 2'd1) begin
                  next_state = CID_EXEC; // RL2
               end else begin
                  next_byteIdx = 2'd1;
               end
            end else if (byteIdx == 2'd1) begin
               next_op1 = progData; // RL3
               if (instrLen == 2'd2) begin
                  next_state = CID_EXEC;
               end else begin
                  next_byteIdx = 2'd2;
               end
            end else begin
               next_op2 = progData; // RL4
               next_state = CID_EXEC;
            end
         end
         CID_EXEC: begin
            if (waitCnt != 4'h0) begin
               next_waitCnt = waitCnt - 4'h1; // RL9
            end else begin
               next_done = 1'b1;
               next_byteIdx = 2'd0;
               next_state = CID_REQ;
               casez (opcode)
                  `CID_OP_RL: next_acc = {accOut[6:0], accOut[7]}; // RL13
                  8'b0010_01??, 8'b0010_1???, 8'b0011_01??, 8'b0011_1???: begin
                     next_acc = sum9[7:0]; // RL11
                     next_carry = sum9[8];
                     next_aux = sumLow[4];
                     next_overflow = (accOut[7] == srcVal[7]) && (sum9[7] != accOut[7]);
                  end
                  `CID_OP_MOV_A_IMM, `CID_OP_MOV_A_DIR, 8'b1110_011?, 8'b1110_1???: begin
                     next_acc = srcVal; // RL11
                  end
                  `CID_OP_MOV_DD: begin
                     dstEn = 1'b1;
                     dstAddr = op2;
                     dstVal = readDirect(op1); // RL6
                  end
                  `CID_OP_MOV_DIR_A: begin
                     dstEn = 1'b1;
                  end
                  8'b1111_1???: begin
                     memWr = 1'b1; // RL7
                  end
                  `CID_OP_MUL: begin
                     next_acc = product[7:0]; // RL12
                     next_b = product[15:8];
                     next_carry = 1'b0;
                     next_overflow = (product[15:8] != 8'h00);
                  end
                  `CID_OP_SJMP: next_pc = pc + {{8{op1[7]}}, op1}; // RL5
                  `CID_OP_JZ, `CID_OP_JNZ: begin
                     if ((accOut == 8'h00) == (opcode == `CID_OP_JZ)) begin
                        next_pc = pc + {{8{op1[7]}}, op1}; // RL5
                     end
                  end
                  `CID_OP_MOV_PTR16: next_dataPtr = {op1, op2};
                  `CID_OP_XMOVE_RD: next_acc = xdataRdata;
                  `CID_OP_XMOVE_WR: begin
                     next_xdataWr = 1'b1;
                     next_xdataWdata = accOut;
                  end
                  default: next_acc = accOut;
               endcase
               // Upper direct range is special registers, never memory
               if (dstEn && !dstAddr[7]) begin
                  memWr = 1'b1; // RL6
                  memAddr = dstAddr;
                  memData = dstVal;
               end else if (dstEn && dstAddr == `CID_SFR_ACC) begin
                  next_acc = dstVal;
               end else if (dstEn && dstAddr == `CID_SFR_B) begin
                  next_b = dstVal;
               end else if (dstEn && dstAddr == `CID_SFR_DPL) begin
                  next_dataPtr = {data_pointer_pair[15:8], dstVal};
               end else if (dstEn && dstAddr == `CID_SFR_DPH) begin
                  next_dataPtr = {dstVal, data_pointer_pair[7:0]};
               end
            end
         end
         default: next_state = CID_REQ;
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state <= CID_REQ;
         pc <= `CID_RST_PC;
         opcode <= `CID_RST_BYTE;
         op1 <= `CID_RST_BYTE;
         op2 <= `CID_RST_BYTE;
         byteIdx <= 2'd0;
         waitCnt <= 4'h0;
         instrLen <= 2'd1;
         instrCycles <= `CID_CYC_ONE;
         accOut <= `CID_RST_BYTE;
         auxRegOut <= `CID_RST_BYTE;
         data_pointer_pair <= 16'h0000;
         carryFlag <= 1'b0;
         auxCarryFlag <= 1'b0;
         overflowFlag <= 1'b0;
         parityFlag <= 1'b0;
         progRd <= 1'b0;
         progAddr <= `CID_RST_PC;
         instrDone <= 1'b0;
         xdataWr <= 1'b0;
         xdataWdata <= `CID_RST_BYTE;
      end else begin
         state <= next_state;
         pc <= next_pc;
         opcode <= next_opcode;
         op1 <= next_op1;
         op2 <= next_op2;
         byteIdx <= next_byteIdx;
         waitCnt <= next_waitCnt;
         instrLen <= next_instrLen;
         instrCycles <= next_instrCycles;
         accOut <= next_acc;
         auxRegOut <= next_b;
         data_pointer_pair <= next_dataPtr;
         carryFlag <= next_carry;
         auxCarryFlag <= next_aux;
         overflowFlag <= next_overflow;
         parityFlag <= ^next_acc; // RL11
         progRd <= next_progRd;
         progAddr <= next_progAddr;
         instrDone <= next_done;
         xdataWr <= next_xdataWr;
         xdataWdata <= next_xdataWdata;
      end
   end

   // Memory has no reset; software must initialise it
   always_ff @(posedge core_clk) begin
      if (memWr) begin
         idata[memAddr] <= memData;
      end
   end

   ////////////////////////////////////////////////////////////////////
   logic [3:0] execCnt;
   logic [1:0] fetchCnt;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         execCnt <= 4'h0;
         fetchCnt <= 2'd0;
      end else begin
         execCnt <= (state == CID_EXEC) ? execCnt + 4'h1 : 4'h0;
         fetchCnt <= instrDone ? {1'b0, progRd} : fetchCnt + {1'b0, progRd};
      end
   end

   lenLegal_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL1
      instrDone |-> (instrLen != 2'd0 && fetchCnt == instrLen))
      else $error("fetched bytes differ from decoded length");
   cycleCount_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL10
      instrDone |-> execCnt == instrCycles)
      else $error("execute cycles differ from cycle count");
   directMove_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL10
      instrDone && opcode == `CID_OP_MOV_DD |-> instrCycles == 4'h2 && instrLen == 2'd3)
      else $error("direct to direct move has wrong timing");
   moveStretch_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL9
      instrDone && opcode == `CID_OP_XMOVE_RD |->
      instrCycles == 4'h1 + {1'b0, $past(external_move_timing_ctrl, 2)})
      else $error("external move not stretched");
   relBranch_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL5
      instrDone && opcode == `CID_OP_SJMP |-> pc == $past(pc) + {{8{op1[7]}}, op1})
      else $error("relative branch target wrong");
   addFlags_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL11
      instrDone && opcode == `CID_OP_ADD_IMM |->
      {carryFlag, accOut} == {1'b0, $past(accOut)} + {1'b0, op1} && parityFlag == ^accOut)
      else $error("add result or carry wrong");
   moveFlags_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL11
      instrDone && opcode == `CID_OP_MOV_A_IMM |->
      $stable(carryFlag) && $stable(auxCarryFlag) && $stable(overflowFlag))
      else $error("move disturbed arithmetic flags");
   mulSplit_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL12
      instrDone && opcode == `CID_OP_MUL |->
      {auxRegOut, accOut} == $past(accOut) * $past(auxRegOut))
      else $error("multiply product misplaced");
   rotLeft_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL13
      instrDone && opcode == `CID_OP_RL |->
      accOut == {$past(accOut[6:0]), $past(accOut[7])} && $stable(carryFlag))
      else $error("rotate left wrong");
   bankReg_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL7
      instrDone && opcode[7:3] == 5'b11111 |-> idata[regAddr] == accOut)
      else $error("working register not written");
   indPtr_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL8
      instrDone && opcode[7:1] == 7'b1110011 |-> accOut == idata[ptrVal])
      else $error("indirect read wrong");
   dirStore_a: assert property (@(posedge core_clk) disable iff (!nrst) // RL6
      instrDone && opcode == `CID_OP_MOV_DIR_A && !op1[7] |-> idata[op1] == accOut)
      else $error("direct store wrong");
endmodule : cid_core

// >>> hw/cid_defs.svh
`ifndef CID_DEFS_SVH
`define CID_DEFS_SVH

// Special function register addresses seen by direct operands
`define CID_SFR_ACC 8'hE0
`define CID_SFR_B 8'hF0
`define CID_SFR_DPL 8'h82
`define CID_SFR_DPH 8'h83

// Reset values
`define CID_RST_BYTE 8'h00
`define CID_RST_PC 16'h0000

// Timing counts in instruction cycles
`define CID_CYC_ONE 4'h1
`define CID_CYC_TWO 4'h2

// Opcodes that the sequencer executes
`define CID_OP_NOP 8'h00
`define CID_OP_RL 8'h23
`define CID_OP_ADD_IMM 8'h24
`define CID_OP_ADDC_IMM 8'h34
`define CID_OP_JZ 8'h60
`define CID_OP_JNZ 8'h70
`define CID_OP_MOV_A_IMM 8'h74
`define CID_OP_SJMP 8'h80
`define CID_OP_MOV_DD 8'h85
`define CID_OP_MOV_PTR16 8'h90
`define CID_OP_MUL 8'hA4
`define CID_OP_XMOVE_RD 8'hE0
`define CID_OP_MOV_A_DIR 8'hE5
`define CID_OP_MOV_A_IND 8'hE6
`define CID_OP_XMOVE_WR 8'hF0
`define CID_OP_MOV_DIR_A 8'hF5
`define CID_OP_MOV_REG_A 8'hF8

`endif

// >>> hw/cid_pkg.sv
package cid_pkg;
   typedef enum logic [1:0] {
      CID_REQ = 2'b00,
      CID_WAIT = 2'b01,
      CID_CAP = 2'b10,
      CID_EXEC = 2'b11
   } cid_state_e;
endpackage : cid_pkg

// >>> hw/cid_len_decode.sv
`timescale 1ns/1ps
`include "cid_defs.svh"
module cid_len_decode
   import cid_pkg::*;
(
   input wire logic [7:0] opcode,
   input wire logic [2:0] moveTiming,
   output logic [1:0] byteLen,
   output logic [3:0] cycles
);
   ////////////////////////////////////////////////////////////////////
   always_comb begin
      byteLen = 2'd1; // RL2
      casez (opcode)
         8'h02, 8'h12, 8'h10, 8'h20, 8'h30, 8'h43, 8'h53, 8'h63, 8'h75, 8'h85,
         8'h90, 8'hB4, 8'hB5, 8'b1011011?, 8'b10111???, 8'hD5: begin
            byteLen = 2'd3; // RL4
         end
         8'b????0001, 8'h40, 8'h50, 8'h60, 8'h70, 8'h80, 8'h05, 8'h15,
         8'h24, 8'h34, 8'h44, 8'h54, 8'h64, 8'h74, 8'h94,
         8'h25, 8'h35, 8'h45, 8'h55, 8'h65, 8'h95, 8'hC5, 8'hE5, 8'hF5,
         8'h42, 8'h52, 8'h62, 8'h72, 8'h82, 8'h92, 8'hA0, 8'hA2, 8'hB0, 8'hB2,
         8'hC0, 8'hC2, 8'hD0, 8'hD2, 8'b0111011?, 8'b01111???, 8'b1000011?,
         8'b10001???, 8'b1010011?, 8'b10101???, 8'b11011???: begin
            byteLen = 2'd2; // RL3
         end
         default: begin
            byteLen = 2'd1; // RL2
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      cycles = (byteLen == 2'd1) ? `CID_CYC_ONE : `CID_CYC_TWO; // RL10
      casez (opcode)
         8'h74, 8'h24, 8'h34, 8'h44, 8'h54, 8'h64, 8'h94, 8'h75, 8'h90, 8'hE5,
         8'hF5, 8'b0111011?, 8'b01111???, 8'b10001???: begin
            cycles = `CID_CYC_ONE; // RL10
         end
         8'b0000011?, 8'b0001011?, 8'b0010011?, 8'b0011011?, 8'b0100011?,
         8'b0101011?, 8'b0110011?, 8'b1001011?, 8'b1100011?, 8'b1101011?,
         8'hA3, 8'h22, 8'h32: begin
            cycles = `CID_CYC_TWO; // RL10
         end
         // Stretch lets slow external data memory keep up
         8'hE0, 8'hF0, 8'b1110001?, 8'b1111001?: begin
            cycles = `CID_CYC_ONE + {1'b0, moveTiming}; // RL9
         end
         default: begin
            cycles = cycles;
         end
      endcase
   end
endmodule : cid_len_decode

// >>> verif/cid_prog_mem.sv
`timescale 1ns/1ps
module cid_prog_mem (
   input wire logic core_clk,
   input wire logic [15:0] progAddr,
   input wire logic progRd,
   output logic [7:0] progData,
   input wire logic [15:0] data_pointer_pair,
   input wire logic xdataWr,
   input wire logic [7:0] xdataWdata,
   output logic [7:0] xdataRdata
);
   // Only 256 bytes each; upper address bits ignored
   logic [7:0] rom [256];
   logic [7:0] xmem [256];
   logic [7:0] held = 8'h00;
   logic [1:0] validCnt = 2'h0;
   ////////////////////////////////////////
   always @(posedge core_clk) begin
      if (progRd) begin
         held <= rom[progAddr[7:0]];
         validCnt <= 2'h2;
      end else if (validCnt != 2'h0) begin
         validCnt <= validCnt - 2'h1;
      end
      if (xdataWr) begin
         xmem[data_pointer_pair[7:0]] <= xdataWdata;
      end
   end
   // Inverse after the hold runs out, so a late sample never looks right
   assign progData = (validCnt != 2'h0) ? held : ~held;
   assign xdataRdata = xmem[data_pointer_pair[7:0]];
endmodule : cid_prog_mem

// >>> verif/cpu_instruction_decode_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin errorCnt++; \
   $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module cpu_instruction_decode_tb_top;
   logic core_clk;
   logic nrst;
   logic [15:0] progAddr;
   logic progRd;
   logic [7:0] progData;
   logic [1:0] bankSel;
   logic [2:0] moveTiming;
   logic [15:0] dataPtr;
   logic xdataWr;
   logic [7:0] xdataWdata;
   logic [7:0] xdataRdata;
   logic [7:0] accOut;
   logic [7:0] auxRegOut;
   logic carryFlag, auxCarryFlag, overflowFlag, parityFlag, instrDone;
   logic [1:0] instrLen;
   logic [3:0] instrCycles;
   int errorCnt = 0;
   int compares = 0;
   logic [31:0] seed = 32'd79;
   logic [7:0] rom [256];
   logic [7:0] im [256];
   logic [7:0] xm [256];
   logic [7:0] acc, bReg, mBank;
   logic [15:0] mpc, mPtr;
   logic mCarry, mAux, mOvf;
   int wp, fIdx, wrCnt, startCyc, cyc, nDone;
   ////////////////////////////////////////
   cid_core u_cid_core (.core_clk(core_clk), .nrst(nrst), .progAddr(progAddr),
      .progRd(progRd), .progData(progData), .bankSel(bankSel),
      .external_move_timing_ctrl(moveTiming), .data_pointer_pair(dataPtr), .xdataWr(xdataWr),
      .xdataWdata(xdataWdata), .xdataRdata(xdataRdata), .accOut(accOut),
      .auxRegOut(auxRegOut), .carryFlag(carryFlag), .auxCarryFlag(auxCarryFlag),
      .overflowFlag(overflowFlag), .parityFlag(parityFlag), .instrDone(instrDone),
      .instrLen(instrLen), .instrCycles(instrCycles));
   cid_prog_mem u_cid_prog_mem (.core_clk(core_clk), .progAddr(progAddr), .progRd(progRd),
      .progData(progData), .data_pointer_pair(dataPtr), .xdataWr(xdataWr),
      .xdataWdata(xdataWdata), .xdataRdata(xdataRdata));
   ////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic [5:0] lenCyc(input logic [7:0] op);
      case (op)
         8'h85: return {2'h3, 4'h2};
         8'h90: return {2'h3, 4'h1};
         8'h25, 8'h60, 8'h70, 8'h80: return {2'h2, 4'h2};
         8'h74, 8'h24, 8'h34, 8'hF5, 8'hE5: return {2'h2, 4'h1};
         8'hE0, 8'hF0: return {2'h1, 4'h1 + {1'b0, moveTiming}};
         default: return {2'h1, 4'h1};
      endcase
   endfunction : lenCyc
   task automatic put(input logic [7:0] v);
      rom[wp[7:0]] = v;
      wp++;
   endtask : put
   task automatic addAcc(input logic [7:0] v, input logic c);
      int s;
      s = acc + v + c;
      mAux = ((acc & 8'h0F) + (v & 8'h0F) + c) > 15;
      mOvf = (((acc & 8'h7F) + (v & 8'h7F) + c) > 127) ^ (s > 255);
      mCarry = s > 255;
      acc = 8'(s);
   endtask : addAcc
   // Writes avoid bank registers 0 and 1, which hold the indirect pointers
   task automatic emit();
      logic [7:0] wd;
      logic [7:0] rd;
      wd = mBank + 8'h02 + 8'(rnd() % 6);
      rd = mBank + 8'(rnd() % 8);
      case (rnd() % 17)
         0: begin put(8'h74); put(8'(rnd())); end
         1: begin put(8'h24); put(8'(rnd())); end
         2: begin put(8'h34); put(8'(rnd())); end
         3: put(8'h23);
         4: put(8'hA4);
         5: put(8'h00);
         // Moves reach the aux register only through its direct address; multiply also writes it
         6: begin put(8'hF5); put((rnd() % 3 == 0) ? 8'hF0 : wd); end
         7: begin put(8'hE5); put((rnd() % 4 == 0) ? 8'hF0 : rd); end
         8: begin put(8'h85); put(rd); put(wd); end
         9: begin put(8'h90); put(8'(rnd())); put(8'(rnd())); end
         10: put(8'hF0);
         11: put(8'hE0);
         12: put(8'hF8 + {5'h00, wd[2:0]});
         13: put(8'hE8 + {5'h00, rd[2:0]});
         14: put(8'hE6 + {7'h00, rd[0]});
         15: begin put(8'h25); put(rd); end
         default: put(8'h38 + {5'h00, rd[2:0]});
      endcase
   endtask : emit
   task automatic execOne();
      logic [7:0] op, o1, o2;
      logic [5:0] lcv;
      logic [15:0] nx, prod;
      op = rom[mpc[7:0]];
      o1 = rom[mpc[7:0] + 8'h01];
      o2 = rom[mpc[7:0] + 8'h02];
      lcv = lenCyc(op);
      nx = mpc + {14'h0000, lcv[5:4]};
      `CHK("fetches", int'(lcv[5:4]), fIdx)
      `CHK("instrLen", lcv[5:4], instrLen)
      `CHK("instrCycles", lcv[3:0], instrCycles)
      // Strobe shows one cycle after the fetch state starts
      `CHK("latency", 3 * int'(lcv[5:4]) + int'(lcv[3:0]) - 1, cyc - startCyc)
      `CHK("xdataWr", (op == 8'hF0) ? 1 : 0, wrCnt)
      case (op)
         8'h74: acc = o1;
         8'h24: addAcc(o1, 1'b0);
         8'h34: addAcc(o1, mCarry);
         8'h23: acc = {acc[6:0], acc[7]};
         8'hA4: begin
            prod = acc * bReg;
            acc = prod[7:0];
            bReg = prod[15:8];
            mCarry = 1'b0;
            mOvf = prod[15:8] != 8'h00;
         end
         8'hF5: begin
            if (o1 == 8'hF0) bReg = acc;
            else im[o1] = acc;
         end
         8'hE5: acc = (o1 == 8'hF0) ? bReg : im[o1];
         8'h85: im[o2] = im[o1];
         8'h90: mPtr = {o1, o2};
         8'hF0: xm[mPtr[7:0]] = acc;
         8'hE0: acc = xm[mPtr[7:0]];
         8'h25: addAcc(im[o1], 1'b0);
         8'h60: if (acc == 8'h00) nx = nx + {{8{o1[7]}}, o1};
         8'h70: if (acc != 8'h00) nx = nx + {{8{o1[7]}}, o1};
         8'h80: nx = nx + {{8{o1[7]}}, o1};
         8'hE6, 8'hE7: acc = im[im[mBank + {7'h00, op[0]}]];
         default: begin
            if (op[7:3] == 5'h1F) im[mBank + {5'h00, op[2:0]}] = acc;
            else if (op[7:3] == 5'h1D) acc = im[mBank + {5'h00, op[2:0]}];
            else if (op[7:3] == 5'h07) addAcc(im[mBank + {5'h00, op[2:0]}], mCarry);
         end
      endcase
      `CHK("accOut", acc, accOut)
      `CHK("auxRegOut", bReg, auxRegOut)
      `CHK("carryFlag", mCarry, carryFlag)
      `CHK("auxCarryFlag", mAux, auxCarryFlag)
      `CHK("overflowFlag", mOvf, overflowFlag)
      `CHK("parityFlag", ^acc, parityFlag)
      `CHK("dataPtr", mPtr, dataPtr)
      mpc = nx;
   endtask : execOne
   ////////////////////////////////////////
   task automatic runProgram();
      int k;
      int j;
      int r;
      @(posedge core_clk);
      nrst <= 1'b0;
      bankSel <= 2'(rnd());
      moveTiming <= 3'(rnd());
      @(posedge core_clk);
      mBank = {3'h0, bankSel, 3'h0};
      wp = 0;
      for (k = 0; k < 8; k++) begin
         put(8'h74);
         put((k < 2) ? mBank + 8'h02 + 8'(rnd() % 6) : 8'(rnd()));
         put(8'hF5);
         put(mBank + 8'(k));
      end
      // Each branch skips exactly the next instruction, so taken and not taken differ
      for (k = 0; k < 30; k++) begin
         if (rnd() % 5 == 0) begin
            r = rnd() % 3;
            put((r == 0) ? 8'h60 : (r == 1) ? 8'h70 : 8'h80);
            j = wp;
            put(8'h00);
            emit();
            rom[j[7:0]] = 8'(wp - j - 1);
         end else begin
            emit();
         end
      end
      put(8'h80);
      put(8'hFE);
      for (k = 0; k < 256; k++) begin
         xm[k] = 8'(rnd());
         u_cid_prog_mem.xmem[k] = xm[k];
         u_cid_prog_mem.rom[k] = rom[k];
      end
      repeat (20) @(posedge core_clk);
      nrst <= 1'b1;
      acc = 8'h00;
      bReg = 8'h00;
      {mCarry, mAux, mOvf} = 3'h0;
      mPtr = 16'h0000;
      mpc = 16'h0000;
      {fIdx, wrCnt, nDone, cyc, startCyc} = '0;
      while (nDone < 60) begin
         @(posedge core_clk);
         #1;
         cyc++;
         if (progRd === 1'b1) begin
            if (fIdx == 0) startCyc = cyc;
            `CHK("progAddr", mpc + 16'(fIdx), progAddr)
            fIdx++;
         end
         if (xdataWr === 1'b1) begin
            wrCnt++;
            `CHK("xdataWdata", acc, xdataWdata)
         end
         if (instrDone === 1'b1) begin
            execOne();
            fIdx = 0;
            wrCnt = 0;
            nDone++;
         end
      end
   endtask : runProgram
   task automatic printVerdict();
      if (errorCnt == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : printVerdict
   ////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // Six programs of about 400 cycles each; far below this bound
   initial begin
      repeat (60000) @(posedge core_clk);
      errorCnt++;
      printVerdict();
   end
   initial begin
      nrst = 1'b0;
      bankSel = 2'h0;
      moveTiming = 3'h0;
      for (int p = 0; p < 6; p++) runProgram();
      printVerdict();
   end
endmodule : cpu_instruction_decode_tb_top
